/* File: umr_consts.vh */
// Constants for the serial element's register set and reset values
`ifndef UMR_CONSTS_VH
`define UMR_CONSTS_VH

// Register offsets on the three address lines
`define UMR_OFS_DATA 3'h0
`define UMR_OFS_IER 3'h1
`define UMR_OFS_IIR 3'h2
`define UMR_OFS_LCR 3'h3
`define UMR_OFS_MCR 3'h4
`define UMR_OFS_LST 3'h5
`define UMR_OFS_MSR 3'h6
`define UMR_OFS_SCR 3'h7

// Field positions
`define UMR_FCR_EN 0
`define UMR_FCR_RXCLR 1
`define UMR_FCR_TXCLR 2
`define UMR_LCR_BREAK 6
`define UMR_LCR_DLAB 7
`define UMR_IER_RDA 0
`define UMR_IER_THRE 1
`define UMR_IER_RLS 2
`define UMR_IER_MS 3

// Reset values
`define UMR_IER_RST 4'h0
`define UMR_MCR_RST 4'h0
`define UMR_LCR_RST 8'h00
`define UMR_FCR_RST 4'h0
`define UMR_IIR_NONE 4'h1
`define UMR_LST_RST 8'h60

// Interrupt identification codes, bits 3..0
`define UMR_IID_RLS 4'h6
`define UMR_IID_RDA 4'h4
`define UMR_IID_THRE 4'h2
`define UMR_IID_MS 4'h0

// Buffer geometry
`define UMR_FIFO_DEPTH 32
`define UMR_FIFO_AW 5
`define UMR_RX_W 12

`endif

/* File: umr_uart.v */
// Serial comms element core: master reset behaviour, registers, FIFOs
`timescale 1ns/10ps
`include "umr_consts.vh"

// How it works
// - Master reset high restores all defined states
// - Interrupt enable bits cleared on reset
// - Identification reads one, other bits zero
// - Modem control cleared, upper nibble always zero
// - Line status resets to 0x60
// - Modem deltas cleared, upper bits follow pins
// - Divisor bytes change only on host write
// - Holding and buffer change only by data
// - Baud output low until divisor written
// - Receive FIFO cleared on reset or control
// - Transmit FIFO cleared on reset or control
// - FIFO control bits cleared on reset
// - Data bus driven only during selected strobe

// Synchronous FIFO with valid/ready on both sides
module umr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk_sys,
    input wire clear,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array
    reg [AW-1:0] wr_ptr_reg; // Write index
    reg [AW-1:0] rd_ptr_reg; // Read index
    reg [AW:0] count_reg; // Words held
    wire push;
    wire pop;

    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointer and count upkeep; clear empties without touching storage
    always @(posedge clk_sys) begin
        if (clear) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Storage write, no reset needed on data
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
endmodule // umr_fifo

// Register file and reset logic of the serial element
module umr_uart (
    input wire clk_sys,
    input wire rst_b,
    input wire master_reset_in,
    input wire chip_select,
    input wire [2:0] reg_addr,
    input wire read_strobe_high,
    input wire write_strobe_high,
    input wire [7:0] bus_data_in,
    output wire [7:0] bus_data_out,
    output wire bus_data_oe,
    output wire bus_driver_disable,
    input wire rx_char_valid,
    input wire [7:0] rx_char_data,
    input wire [2:0] rx_char_err,
    input wire rx_char_break,
    output wire tx_char_valid,
    input wire tx_char_ready,
    output wire [7:0] tx_char_data,
    input wire [3:0] modem_in,
    output wire serial_tx_line,
    output wire rts_n,
    output wire dtr_n,
    output wire out1_n,
    output wire out2_n,
    output wire baud_clock_output,
    output wire irq
);
    // Reset of either kind; master reset is sampled as a synchronous level
    wire rst_any = ~rst_b | master_reset_in;

    // Control and status state
    reg [3:0] ier_reg; // Interrupt enables
    reg [7:0] lcr_reg; // Line control
    reg [3:0] mcr_reg; // Modem control, upper nibble always zero
    reg [3:0] fcr_reg; // FIFO enable, clears, DMA select
    reg [1:0] trig_reg; // Receive trigger level
    reg [3:0] lst_err_reg; // Overrun, parity, framing, break
    reg lst_fifo_err_reg; // Error pushed into receive FIFO since its last clear
    reg [3:0] msr_delta_reg; // Modem change indicators
    reg [3:0] modem_q_reg; // Previous modem pin levels
    reg thre_pend_reg; // Transmit-empty interrupt pending
    reg tx_empty_q_reg; // Previous transmit FIFO empty state
    reg baud_run_reg; // Divisor has been written
    reg [15:0] baud_cnt_reg; // Baud divider count
    reg baud_pulse_reg; // Baud output flop
    reg brk_reg; // Serial line value
    reg rd_q_reg; // Read strobe one cycle ago
    reg wr_q_reg; // Write strobe one cycle ago
    reg [7:0] dout_reg; // Read data latch

    // Data holding state, untouched by either reset
    reg [7:0] dll_reg; // Divisor low byte
    reg [7:0] dlm_reg; // Divisor high byte
    reg [7:0] thr_reg; // Last byte written for transmit
    reg [7:0] rxbuf_reg; // Last byte received
    reg [7:0] scr_reg; // Scratch byte

    // Access decode: one access per strobe rising edge
    wire rd_act = chip_select & read_strobe_high;
    wire wr_act = chip_select & write_strobe_high;
    wire rd_ev = rd_act & ~rd_q_reg;
    wire wr_ev = wr_act & ~wr_q_reg;
    wire dlab = lcr_reg[`UMR_LCR_DLAB];
    wire fen = fcr_reg[`UMR_FCR_EN];

    // Address decoder shared by read and write paths
    function is_reg;
        input [2:0] a;
        input [2:0] ofs;
        begin
            is_reg = (a == ofs);
        end
    endfunction

    wire a_data = is_reg(reg_addr, `UMR_OFS_DATA);
    wire a_ier = is_reg(reg_addr, `UMR_OFS_IER);
    wire wr_thr = wr_ev & a_data & ~dlab;
    wire wr_dll = wr_ev & a_data & dlab;
    wire wr_dlm = wr_ev & a_ier & dlab;
    wire wr_fcr = wr_ev & is_reg(reg_addr, `UMR_OFS_IIR);
    wire rd_rxbuf = rd_ev & a_data & ~dlab;
    wire rd_iir = rd_ev & is_reg(reg_addr, `UMR_OFS_IIR);
    wire rd_lst = rd_ev & is_reg(reg_addr, `UMR_OFS_LST);
    wire rd_msr = rd_ev & is_reg(reg_addr, `UMR_OFS_MSR);

    // FIFO clears: reset, clear bit with enable, or enable toggling
    wire en_change = wr_fcr & (bus_data_in[`UMR_FCR_EN] != fen);
    wire rx_clr = rst_any | en_change |
        (wr_fcr & bus_data_in[`UMR_FCR_EN] &
        bus_data_in[`UMR_FCR_RXCLR]);
    wire tx_clr = rst_any | en_change |
        (wr_fcr & bus_data_in[`UMR_FCR_EN] &
        bus_data_in[`UMR_FCR_TXCLR]);

    // Receive FIFO; character mode keeps at most one entry
    wire rx_in_ready;
    wire rx_out_valid;
    wire [`UMR_RX_W-1:0] rx_out_data;
    wire rx_room = fen ? rx_in_ready : ~rx_out_valid;
    wire rx_push = rx_char_valid & rx_room;
    wire rx_overrun = rx_char_valid & ~rx_room;
    wire [3:0] rx_new_err = {rx_char_break, rx_char_err};

    umr_fifo #(
        .WIDTH(`UMR_RX_W),
        .DEPTH(`UMR_FIFO_DEPTH),
        .AW(`UMR_FIFO_AW)
    ) u_rx_fifo (
        .clk_sys(clk_sys),
        .clear(rx_clr),
        .in_valid(rx_push),
        .in_ready(rx_in_ready),
        .in_data({rx_new_err, rx_char_data}),
        .out_valid(rx_out_valid),
        .out_ready(rd_rxbuf),
        .out_data(rx_out_data)
    );

    // Transmit FIFO; a full FIFO drops the host byte without notice
    wire tx_in_ready;
    wire tx_empty = ~tx_char_valid;

    umr_fifo #(
        .WIDTH(8),
        .DEPTH(`UMR_FIFO_DEPTH),
        .AW(`UMR_FIFO_AW)
    ) u_tx_fifo (
        .clk_sys(clk_sys),
        .clear(tx_clr),
        .in_valid(wr_thr),
        .in_ready(tx_in_ready),
        .in_data(bus_data_in),
        .out_valid(tx_char_valid),
        .out_ready(tx_char_ready),
        .out_data(tx_char_data)
    );

    // Line status image; empty FIFOs after reset give 0x60
    wire [7:0] lst_val = {lst_fifo_err_reg & fen, tx_empty, tx_empty,
        lst_err_reg, rx_out_valid};

    // Interrupt sources in priority order
    wire src_rls = ier_reg[`UMR_IER_RLS] & (|lst_err_reg);
    wire src_rda = ier_reg[`UMR_IER_RDA] & rx_out_valid;
    wire src_thre = ier_reg[`UMR_IER_THRE] & thre_pend_reg;
    wire src_ms = ier_reg[`UMR_IER_MS] & (|msr_delta_reg);
    reg [3:0] iid;

    // Identification priority encoder
    always @* begin
        if (src_rls) begin
            iid = `UMR_IID_RLS;
        end else if (src_rda) begin
            iid = `UMR_IID_RDA;
        end else if (src_thre) begin
            iid = `UMR_IID_THRE;
        end else if (src_ms) begin
            iid = `UMR_IID_MS;
        end else begin
            iid = `UMR_IIR_NONE;
        end
    end

    // Read multiplexer; bits 4 and 5 of the identification stay zero
    reg [7:0] rd_mux;
    always @* begin
        if (a_data) begin
            rd_mux = dlab ? dll_reg :
                (rx_out_valid ? rx_out_data[7:0] : rxbuf_reg);
        end else if (a_ier) begin
            rd_mux = dlab ? dlm_reg : {4'h0, ier_reg};
        end else if (is_reg(reg_addr, `UMR_OFS_IIR)) begin
            rd_mux = {fen, fen, 2'b00, iid};
        end else if (is_reg(reg_addr, `UMR_OFS_LCR)) begin
            rd_mux = lcr_reg;
        end else if (is_reg(reg_addr, `UMR_OFS_MCR)) begin
            rd_mux = {4'h0, mcr_reg};
        end else if (is_reg(reg_addr, `UMR_OFS_LST)) begin
            rd_mux = lst_val;
        end else if (is_reg(reg_addr, `UMR_OFS_MSR)) begin
            rd_mux = {modem_in, msr_delta_reg};
        end else begin
            rd_mux = scr_reg;
        end
    end

    // Bus pins: driven only while selected and reading
    assign bus_data_oe = rd_act;
    assign bus_data_out = dout_reg;
    assign bus_driver_disable = ~rd_act;

    // Strobe history and read latch
    always @(posedge clk_sys) begin
        if (rst_any) begin
            rd_q_reg <= 1'b0;
            wr_q_reg <= 1'b0;
            dout_reg <= 8'h00;
        end else begin
            rd_q_reg <= rd_act;
            wr_q_reg <= wr_act;
            if (rd_ev) begin
                dout_reg <= rd_mux;
            end
        end
    end

    // Control registers, cleared by master reset
    always @(posedge clk_sys) begin
        if (rst_any) begin
            ier_reg <= `UMR_IER_RST;
            lcr_reg <= `UMR_LCR_RST;
            mcr_reg <= `UMR_MCR_RST;
            fcr_reg <= `UMR_FCR_RST;
            trig_reg <= 2'b00;
        end else begin
            if (wr_ev & a_ier & ~dlab) begin
                ier_reg <= bus_data_in[3:0];
            end
            if (wr_ev & is_reg(reg_addr, `UMR_OFS_LCR)) begin
                lcr_reg <= bus_data_in;
            end
            if (wr_ev & is_reg(reg_addr, `UMR_OFS_MCR)) begin
                mcr_reg <= bus_data_in[3:0];
            end
            if (wr_fcr) begin
                // Clear bits are self-clearing; only enable and DMA stay
                fcr_reg <= {bus_data_in[3], 2'b00, bus_data_in[0]};
                trig_reg <= bus_data_in[7:6];
            end
        end
    end

    // Data registers change only by their own data events
    always @(posedge clk_sys) begin
        if (wr_dll) begin
            dll_reg <= bus_data_in;
        end
        if (wr_dlm) begin
            dlm_reg <= bus_data_in;
        end
        if (wr_thr) begin
            thr_reg <= bus_data_in;
        end
        if (rx_char_valid) begin
            rxbuf_reg <= rx_char_data;
        end
        if (wr_ev & is_reg(reg_addr, `UMR_OFS_SCR)) begin
            scr_reg <= bus_data_in;
        end
    end

    // Line status errors: set beats the read that clears them
    always @(posedge clk_sys) begin
        if (rst_any) begin
            lst_err_reg <= 4'h0;
            lst_fifo_err_reg <= 1'b0;
        end else begin
            lst_err_reg <= (rd_lst ? 4'h0 : lst_err_reg) |
                ({rx_new_err[3:1], 1'b0} & {4{rx_push}}) |
                {3'b000, rx_overrun};
            lst_fifo_err_reg <= rx_clr ? 1'b0 :
                (lst_fifo_err_reg | (rx_push & (|rx_new_err)));
        end
    end

    // Modem change detection; trailing edge only for ring indicator
    wire [3:0] modem_chg = {modem_in[3] ^ modem_q_reg[3],
        ~modem_in[2] & modem_q_reg[2],
        modem_in[1] ^ modem_q_reg[1],
        modem_in[0] ^ modem_q_reg[0]};

    always @(posedge clk_sys) begin
        modem_q_reg <= modem_in;
        if (rst_any) begin
            msr_delta_reg <= 4'h0;
        end else begin
            msr_delta_reg <= (rd_msr ? 4'h0 : msr_delta_reg) | modem_chg;
        end
    end

    // Transmit-empty interrupt: raised when FIFO drains, dropped on an
    // identification read reporting it or a new byte; the new empty edge wins
    always @(posedge clk_sys) begin
        if (rst_any) begin
            thre_pend_reg <= 1'b0;
            tx_empty_q_reg <= 1'b1;
        end else begin
            tx_empty_q_reg <= tx_empty;
            if (tx_empty & ~tx_empty_q_reg) begin
                thre_pend_reg <= 1'b1;
            end else if (wr_thr | (rd_iir & (iid == `UMR_IID_THRE))) begin
                thre_pend_reg <= 1'b0;
            end
        end
    end

    // Baud generator: silent until a divisor byte is written
    wire [15:0] divisor = {dlm_reg, dll_reg};
    always @(posedge clk_sys) begin
        if (rst_any) begin
            baud_run_reg <= 1'b0;
            baud_cnt_reg <= 16'h0000;
            baud_pulse_reg <= 1'b0;
        end else begin
            if (wr_dll | wr_dlm) begin
                baud_run_reg <= 1'b1;
                baud_cnt_reg <= 16'h0000;
                baud_pulse_reg <= 1'b0;
            end else if (baud_run_reg & (divisor != 16'h0000)) begin
                // One high cycle per divisor period
                if (baud_cnt_reg >= divisor - 16'h0001) begin
                    baud_cnt_reg <= 16'h0000;
                    baud_pulse_reg <= 1'b1;
                end else begin
                    baud_cnt_reg <= baud_cnt_reg + 16'h0001;
                    baud_pulse_reg <= (divisor == 16'h0001);
                end
            end else begin
                baud_pulse_reg <= 1'b0;
            end
        end
    end

    // Serial line idles high; break bit forces it low
    always @(posedge clk_sys) begin
        if (rst_any) begin
            brk_reg <= 1'b1;
        end else begin
            brk_reg <= ~lcr_reg[`UMR_LCR_BREAK];
        end
    end

    // Outputs; modem pins are inverted control bits, high after reset
    assign serial_tx_line = brk_reg;
    assign baud_clock_output = baud_pulse_reg;
    assign dtr_n = ~mcr_reg[0];
    assign rts_n = ~mcr_reg[1];
    assign out1_n = ~mcr_reg[2];
    assign out2_n = ~mcr_reg[3];
    assign irq = src_rls | src_rda | src_thre | src_ms;
endmodule // umr_uart

/* File: umr_uart_props.sv */
// Checker for the serial element's reset, bus and FIFO-clear behaviour
`timescale 1ns/10ps

module umr_uart_props (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic master_reset_in,
    input wire logic chip_select,
    input wire logic [2:0] reg_addr,
    input wire logic read_strobe_high,
    input wire logic write_strobe_high,
    input wire logic [7:0] bus_data_in,
    input wire logic bus_data_oe,
    input wire logic bus_driver_disable,
    input wire logic tx_char_valid,
    input wire logic serial_tx_line,
    input wire logic rts_n,
    input wire logic dtr_n,
    input wire logic out1_n,
    input wire logic out2_n,
    input wire logic baud_clock_output,
    input wire logic irq
);
    logic wr_prev_reg; // Write strobe seen at the last edge
    logic [7:0] lcr_reg; // Shadow of line control
    logic fen_reg; // Shadow of the FIFO enable bit
    logic div_seen_reg; // A divisor byte written since reset
    wire wr_take = chip_select & write_strobe_high & ~wr_prev_reg;

    // Edge detect: a held strobe counts once only
    always @(posedge clk_sys) begin
        wr_prev_reg <= chip_select & write_strobe_high;
    end

    // Shadow registers, cleared by either reset
    always @(posedge clk_sys) begin
        if (!rst_b || master_reset_in) begin
            lcr_reg <= 8'h00;
            fen_reg <= 1'b0;
            div_seen_reg <= 1'b0;
        end else if (wr_take) begin
            if (reg_addr == 3'h3) begin
                lcr_reg <= bus_data_in;
            end
            if (reg_addr == 3'h2) begin
                fen_reg <= bus_data_in[0];
            end
            if (lcr_reg[7] && reg_addr[2:1] == 2'b00) begin
                div_seen_reg <= 1'b1;
            end
        end
    end

    oe_strobe_a: assert property (@(posedge clk_sys)
        bus_data_oe == (chip_select & read_strobe_high))
        else $error("data bus enable does not follow the read strobe");
    drv_inverse_a: assert property (@(posedge clk_sys)
        bus_driver_disable != bus_data_oe)
        else $error("driver disable is not the inverse of enable");
    reset_pins_a: assert property (@(posedge clk_sys)
        disable iff (!rst_b) master_reset_in |=>
        serial_tx_line && rts_n && dtr_n && out1_n && out2_n)
        else $error("line or modem pins not high after master reset");
    reset_quiet_a: assert property (@(posedge clk_sys)
        disable iff (!rst_b) master_reset_in |=> !irq && !tx_char_valid)
        else $error("interrupt or transmit data left after master reset");
    baud_hold_a: assert property (@(posedge clk_sys)
        disable iff (!rst_b) !div_seen_reg |-> !baud_clock_output)
        else $error("baud output active before a divisor write");
    break_line_a: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        !serial_tx_line |-> lcr_reg[6] || $past(lcr_reg[6]))
        else $error("serial line low without the break bit");
    mcr_pins_a: assert property (@(posedge clk_sys)
        disable iff (!rst_b || master_reset_in)
        wr_take && reg_addr == 3'h4 |=>
        {out2_n, out1_n, rts_n, dtr_n} == ~$past(bus_data_in[3:0]))
        else $error("modem outputs do not match the control write");
    fcr_txclr_a: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        wr_take && reg_addr == 3'h2 && bus_data_in[0] && bus_data_in[2]
        |=> !tx_char_valid)
        else $error("transmit FIFO not cleared by control write");
    fcr_toggle_a: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        wr_take && reg_addr == 3'h2 && bus_data_in[0] != fen_reg
        |=> !tx_char_valid)
        else $error("transmit FIFO not cleared on enable change");
endmodule // umr_uart_props

bind umr_uart umr_uart_props props_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .master_reset_in(master_reset_in),
    .chip_select(chip_select), .reg_addr(reg_addr),
    .read_strobe_high(read_strobe_high),
    .write_strobe_high(write_strobe_high), .bus_data_in(bus_data_in),
    .bus_data_oe(bus_data_oe), .bus_driver_disable(bus_driver_disable),
    .tx_char_valid(tx_char_valid), .serial_tx_line(serial_tx_line),
    .rts_n(rts_n), .dtr_n(dtr_n), .out1_n(out1_n), .out2_n(out2_n),
    .baud_clock_output(baud_clock_output), .irq(irq));

/* File: umr_line_model.sv */
// Model of the serializer side: takes transmit bytes, offers receive bytes
`timescale 1ns/10ps

module umr_line_model (
    input wire logic clk_sys,
    input wire logic stall,
    input wire logic slow,
    input wire logic tx_char_valid,
    input wire logic [7:0] tx_char_data,
    output wire logic tx_char_ready,
    output logic rx_char_valid,
    output logic [7:0] rx_char_data,
    output logic [2:0] rx_char_err,
    output logic rx_char_break
);
    logic phase_reg = 1'b0; // Half-rate acceptance when slow
    logic [7:0] got[$]; // Bytes taken off the transmit side

    // Stalled takes nothing; slow takes every other cycle
    assign tx_char_ready = !stall && (!slow || phase_reg);

    // Record each byte popped by the handshake
    always @(posedge clk_sys) begin
        phase_reg <= !phase_reg;
        if (tx_char_valid && tx_char_ready) begin
            got.push_back(tx_char_data);
        end
    end

    initial begin
        rx_char_valid = 1'b0;
        rx_char_data = 8'h00;
        rx_char_err = 3'h0;
        rx_char_break = 1'b0;
    end

    // One clean character; data inverts after so stale values never match
    task automatic send_char(input logic [7:0] d);
        @(negedge clk_sys);
        rx_char_valid = 1'b1;
        rx_char_data = d;
        @(negedge clk_sys);
        rx_char_valid = 1'b0;
        rx_char_data = ~d;
    endtask
endmodule // umr_line_model

/* File: umr_tb.sv */
// Self-checking bench for the serial element's reset behaviour
`timescale 1ns/10ps

module tb;
    logic clk_sys, rst_b, master_reset_in, chip_select;
    logic read_strobe_high, write_strobe_high, stall, slow;
    logic [2:0] reg_addr;
    logic [7:0] bus_data_in;
    logic [3:0] modem_in;
    wire [7:0] bus_data_out, rx_char_data, tx_char_data;
    wire [2:0] rx_char_err;
    wire bus_data_oe, bus_driver_disable, rx_char_valid, rx_char_break;
    wire tx_char_valid, tx_char_ready, serial_tx_line, rts_n, dtr_n;
    wire out1_n, out2_n, baud_clock_output, irq;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int hits;
    // Pins packed so one compare covers them all
    wire [7:0] pin_vec = {bus_data_oe, bus_driver_disable, baud_clock_output,
        serial_tx_line, rts_n, dtr_n, out1_n, out2_n};

    umr_uart dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
        .master_reset_in(master_reset_in), .chip_select(chip_select),
        .reg_addr(reg_addr), .read_strobe_high(read_strobe_high),
        .write_strobe_high(write_strobe_high), .bus_data_in(bus_data_in),
        .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
        .bus_driver_disable(bus_driver_disable),
        .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
        .rx_char_err(rx_char_err), .rx_char_break(rx_char_break),
        .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready),
        .tx_char_data(tx_char_data), .modem_in(modem_in),
        .serial_tx_line(serial_tx_line), .rts_n(rts_n), .dtr_n(dtr_n),
        .out1_n(out1_n), .out2_n(out2_n),
        .baud_clock_output(baud_clock_output), .irq(irq));

    umr_line_model partner_u (.clk_sys(clk_sys), .stall(stall), .slow(slow),
        .tx_char_valid(tx_char_valid), .tx_char_data(tx_char_data),
        .tx_char_ready(tx_char_ready), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data), .rx_char_err(rx_char_err),
        .rx_char_break(rx_char_break));

    // Clock: 100 MHz
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Hang guard, far above the roughly 1150 cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 8000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp,
        input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Write: strobe for one edge, then a low edge before the next access
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        chip_select = 1'b1;
        reg_addr = a;
        bus_data_in = d;
        write_strobe_high = 1'b1;
        @(negedge clk_sys);
        chk("write_oe", 8'h01, 8'(pin_vec[7:6]));
        write_strobe_high = 1'b0;
        chip_select = 1'b0;
        bus_data_in = ~d;
    endtask

    // Read: data sampled a full cycle after the strobe edge, so the
    // read latch has settled whatever its stage
    task automatic rchk(input string name, input logic [2:0] a,
        input logic [7:0] exp);
        @(negedge clk_sys);
        chip_select = 1'b1;
        reg_addr = a;
        read_strobe_high = 1'b1;
        @(negedge clk_sys);
        chk("read_oe", 8'h02, 8'(pin_vec[7:6]));
        read_strobe_high = 1'b0;
        chip_select = 1'b0;
        @(negedge clk_sys);
        chk(name, exp, bus_data_out);
    endtask

    // Count baud pulses over a stretch of cycles
    task automatic count_baud(input int n);
        hits = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (baud_clock_output === 1'b1) hits++;
        end
    endtask

    // Reset state of every control and status register the host can read
    task automatic reset_regs(input logic [7:0] msr_exp);
        chk("pins", 8'h5f, pin_vec);
        chk("irq_txv", 8'h00, {6'h0, irq, tx_char_valid});
        rchk("ier", 3'h1, 8'h00);
        rchk("iir", 3'h2, 8'h01);
        rchk("lcr", 3'h3, 8'h00);
        rchk("mcr", 3'h4, 8'h00);
        rchk("stat", 3'h5, 8'h60);
        rchk("msr", 3'h6, msr_exp);
    endtask

    initial begin
        rst_b = 1'b0;
        master_reset_in = 1'b0;
        chip_select = 1'b0;
        read_strobe_high = 1'b0;
        write_strobe_high = 1'b0;
        reg_addr = 3'h0;
        bus_data_in = 8'h00;
        modem_in = 4'h3;
        stall = 1'b1;
        slow = 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys) rst_b = 1'b1;
        reset_regs(8'h30);
        // Program everything away from its reset value
        wr(3'h3, 8'h83);
        wr(3'h0, 8'h03);
        wr(3'h1, 8'h01);
        wr(3'h3, 8'h43);
        count_baud(300);
        chk("baud_run", 8'h01, 8'(hits > 0));
        wr(3'h1, 8'h0f);
        wr(3'h4, 8'h0f);
        wr(3'h2, 8'h01);
        wr(3'h0, 8'h11);
        wr(3'h0, 8'h22);
        partner_u.send_char(8'ha7);
        modem_in = 4'hc;
        @(negedge clk_sys);
        chk("irq_set", 8'h01, {7'h0, irq});
        // Master reset pulse, one edge
        master_reset_in = 1'b1;
        @(negedge clk_sys) master_reset_in = 1'b0;
        reset_regs(8'hc0);
        rchk("rxbuf", 3'h0, 8'ha7);
        count_baud(300);
        chk("baud_quiet", 8'h00, 8'(hits));
        wr(3'h3, 8'h80);
        rchk("dll", 3'h0, 8'h03);
        rchk("dlm", 3'h1, 8'h01);
        wr(3'h0, 8'h04);
        count_baud(300);
        chk("baud_again", 8'h01, 8'(hits > 0));
        wr(3'h3, 8'h00);
        // Receive interrupts drop on status and buffer reads
        wr(3'h1, 8'h04);
        partner_u.send_char(8'h01);
        partner_u.send_char(8'h02);
        chk("irq_err", 8'h01, {7'h0, irq});
        rchk("stat_ovr", 3'h5, 8'h63);
        chk("irq_err_rd", 8'h00, {7'h0, irq});
        wr(3'h1, 8'h01);
        chk("irq_data", 8'h01, {7'h0, irq});
        rchk("rxbuf_head", 3'h0, 8'h01);
        chk("irq_data_rd", 8'h00, {7'h0, irq});
        // FIFO clears by control writes
        wr(3'h2, 8'h01);
        partner_u.send_char(8'h3c);
        wr(3'h2, 8'h03);
        rchk("stat_rxclr", 3'h5, 8'h60);
        wr(3'h0, 8'h55);
        chk("txv_held", 8'h01, {7'h0, tx_char_valid});
        wr(3'h2, 8'h05);
        chk("txv_clr", 8'h00, {7'h0, tx_char_valid});
        wr(3'h0, 8'h66);
        partner_u.send_char(8'h77);
        wr(3'h2, 8'h00);
        chk("txv_toggle", 8'h00, {7'h0, tx_char_valid});
        rchk("stat_toggle", 3'h5, 8'h60);
        // Fill the transmit FIFO past full, then drain at half rate
        wr(3'h2, 8'h01);
        for (int i = 0; i < 33; i++) wr(3'h0, 8'(i));
        rchk("stat_full", 3'h5, 8'h00);
        slow = 1'b1;
        stall = 1'b0;
        for (int i = 0; i < 200 && tx_char_valid !== 1'b0; i++) begin
            @(negedge clk_sys);
        end
        chk("popped", 8'h20, 8'(partner_u.got.size()));
        for (int i = 0; i < 32; i++) begin
            chk("tx_byte", 8'(i), partner_u.got[i]);
        end
        wrap_up();
    end
endmodule // tb
